// File: design/reset_cause_pkg.sv
// constants, field layout and modes of the reset cause and init block
// assumes one 10 MHz system clock and a registered AHB-Lite slave port
package reset_cause_pkg;

	// ==========================================================
	// register map: printed index, byte address is four times it
	localparam int ADDR_W = 12;
	localparam logic [7:0] IDX_CPU_STATUS = 8'h03;
	localparam logic [7:0] IDX_RESET_CAUSE = 8'h8e;
	localparam logic [7:0] IDX_IRQ_CONTROL = 8'h0b;
	localparam logic [7:0] IDX_PERIPH_IRQ = 8'h0c;
	localparam logic [7:0] IDX_START_CONFIG = 8'h40;
	localparam logic [11:0] ADDR_CPU_STATUS = {2'h0, IDX_CPU_STATUS, 2'h0};
	localparam logic [11:0] ADDR_RESET_CAUSE = {2'h0, IDX_RESET_CAUSE, 2'h0};
	localparam logic [11:0] ADDR_IRQ_CONTROL = {2'h0, IDX_IRQ_CONTROL, 2'h0};
	localparam logic [11:0] ADDR_PERIPH_IRQ = {2'h0, IDX_PERIPH_IRQ, 2'h0};
	localparam logic [11:0] ADDR_START_CONFIG = {2'h0, IDX_START_CONFIG, 2'h0};
	localparam int HTRANS_ACTIVE_BIT = 1;

	// ==========================================================
	// cpu_status fields
	localparam int DATA_MSB = 7;
	localparam int BANK_LSB = 5;
	localparam int TIMEOUT_FLAG_BIT = 4;
	localparam int POWERDOWN_FLAG_BIT = 3;
	localparam logic [2:0] BANK_ZERO = 3'h0;
	localparam logic [1:0] FLAGS_POWER_UP = 2'h3;
	localparam logic [1:0] FLAGS_PIN_SLEEP = 2'h2;
	localparam logic [1:0] FLAGS_WDOG_WAKE = 2'h0;
	localparam logic [1:0] FLAGS_IRQ_WAKE = 2'h2;
	localparam logic [7:0] STATUS_POR = 8'h18;

	// ==========================================================
	// reset_cause_status (power_control_reg) fields
	localparam int CAUSE_W = 3;
	localparam int BROWNOUT_FLAG_BIT = 0;
	localparam int POWER_ON_FLAG_BIT = 1;
	localparam int SW_BROWNOUT_EN_BIT = 2;
	localparam logic [2:0] CAUSE_POR = 3'h4;
	localparam logic [2:0] CAUSE_BROWNOUT = 3'h6;

	// ==========================================================
	// interrupt registers
	localparam int GLOBAL_IRQ_EN_BIT = 7;
	localparam logic [7:0] GLOBAL_IRQ_EN_MASK = 8'h80;
	localparam logic [7:0] IRQ_REG_RESET = 8'h00;

	// ==========================================================
	// start configuration fields
	localparam int CFG_W = 6;
	localparam int CFG_OSC_LSB = 0;
	localparam int CFG_OSC_MSB = 2;
	localparam int CFG_BROWNOUT_LSB = 3;
	localparam int CFG_BROWNOUT_MSB = 4;
	localparam int CFG_PWRT_N_BIT = 5;
	localparam logic [5:0] CFG_RESET = 6'h19;
	localparam logic [1:0] BROWNOUT_MODE_OFF = 2'h0;

	typedef enum logic [2:0] {
		OSC_LOW_POWER_CRYSTAL,
		OSC_STANDARD_CRYSTAL,
		OSC_HIGH_SPEED_CRYSTAL,
		OSC_EXTERNAL_CLOCK,
		OSC_RESISTOR_CAPACITOR,
		OSC_INTERNAL
	} osc_mode_type;

	// ==========================================================
	// program counter and timing
	localparam int PC_W = 13;
	localparam logic [12:0] RESET_VECTOR = 13'h0000;
	localparam logic [12:0] IRQ_VECTOR = 13'h0004;
	localparam int PWRT_TIME_MS = 64;
	localparam int LF_OSC_HZ = 31000;
	localparam int PWRT_TICKS = (PWRT_TIME_MS * LF_OSC_HZ) / 1000;
	localparam int OST_PERIODS = 1024;
	localparam int TIMER_W = 16;

endpackage

// File: design/startup_timer.sv
// power-up delay followed by oscillator start-up count
// assumes lf_tick is a one-cycle pulse per low-frequency period
module startup_timer
	import reset_cause_pkg::*;
#(
	parameter int PWRT_COUNT = PWRT_TICKS,
	parameter int OST_COUNT = OST_PERIODS
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic pwrt_en,
	input wire logic ost_en,
	input wire logic lf_tick,
	output logic busy
);

	typedef enum logic [1:0] {
		TMR_IDLE,
		TMR_POWERUP,
		TMR_OSC_START
	} timer_state_type;

	timer_state_type state_ff, nxt_state;
	logic [TIMER_W-1:0] cnt_ff, nxt_cnt;
	logic ost_en_ff;

	// ==========================================================
	// terminal counts
	wire pwrt_last = lf_tick && (cnt_ff == TIMER_W'(PWRT_COUNT - 1));
	wire ost_last = (cnt_ff == TIMER_W'(OST_COUNT - 1));
	wire [TIMER_W-1:0] cnt_inc = cnt_ff + TIMER_W'(1);
	assign busy = (state_ff != TMR_IDLE);

	// a new start restarts the whole sequence, so a brown-out
	// during the delay re-arms it from zero
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		if (start) begin
			nxt_cnt = '0;
			if (pwrt_en) begin
				nxt_state = TMR_POWERUP;
			end else if (ost_en) begin
				nxt_state = TMR_OSC_START;
			end else begin
				nxt_state = TMR_IDLE;
			end
		end else begin
			unique case (state_ff)
				TMR_IDLE: begin
					nxt_cnt = cnt_ff;
				end
				TMR_POWERUP: begin
					if (pwrt_last) begin
						nxt_cnt = '0;
						nxt_state = ost_en_ff ? TMR_OSC_START : TMR_IDLE;
					end else if (lf_tick) begin
						nxt_cnt = cnt_inc;
					end
				end
				TMR_OSC_START: begin
					if (ost_last) begin
						nxt_cnt = '0;
						nxt_state = TMR_IDLE;
					end else begin
						nxt_cnt = cnt_inc;
					end
				end
				// unused code: fall back to idle rather than hang
				default: begin
					nxt_cnt = '0;
					nxt_state = TMR_IDLE;
				end
			endcase
		end
	end

	// state, count and the latched oscillator request
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_ff <= TMR_IDLE;
			cnt_ff <= '0;
			ost_en_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			ost_en_ff <= start ? ost_en : ost_en_ff;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_pwrt_bound: assert property (
		state_ff == TMR_POWERUP |-> cnt_ff < TIMER_W'(PWRT_COUNT))
		else $error("power-up count ran past its end");
	a_pwrt_tick_only: assert property (
		state_ff == TMR_POWERUP && !lf_tick && !start |=> $stable(cnt_ff))
		else $error("power-up count moved without a tick");
	a_ost_done: assert property (
		state_ff == TMR_OSC_START && ost_last && !start
		|=> state_ff == TMR_IDLE)
		else $error("start-up count did not end on time");
	a_no_ost_after: assert property (
		state_ff == TMR_POWERUP && pwrt_last && !ost_en_ff && !start
		|=> state_ff == TMR_IDLE)
		else $error("start-up count added for a non-crystal mode");

endmodule

// File: design/reset_cause_init.sv
// reset cause recording, start-up delay control and pc loading
// assumes event inputs are one-cycle pulses already filtered and
// synchronous to CLK; RST_N low stands for the power-on reset
module reset_cause_init
	import reset_cause_pkg::*;
#(
	parameter int PWRT_COUNT = PWRT_TICKS,
	parameter int OST_COUNT = OST_PERIODS
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic BROWNOUT_EVT,
	input wire logic WATCHDOG_EVT,
	input wire logic RESET_PIN_EVT,
	input wire logic IRQ_WAKE_EVT,
	input wire logic [7:0] WAKE_IRQ_BITS,
	input wire logic [7:0] WAKE_PERIPH_BITS,
	input wire logic SLEEP_ACTIVE,
	input wire logic INSTR_DONE,
	input wire logic [12:0] NEXT_PC,
	input wire logic LF_TICK,
	output logic CHIP_HOLD,
	output logic PC_LOAD,
	output logic [12:0] PC_ADDR,
	output logic GLOBAL_IRQ_EN
);

	// ==========================================================
	// state
	logic [7:0] status_ff, nxt_status;
	logic [CAUSE_W-1:0] cause_ff, nxt_cause;
	logic [7:0] irq_ctl_ff, nxt_irq_ctl;
	logic [7:0] periph_ff, nxt_periph;
	logic [CFG_W-1:0] cfg_ff, nxt_cfg;
	logic [ADDR_W-1:0] addr_ff;
	logic wr_ff, rd_ff;
	logic por_pend_ff, load_pend_ff, vec_pend_ff;
	logic [PC_W-1:0] load_addr_ff;
	logic tmr_busy;

	function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] target);
		reg_hit = (a == target);
	endfunction

	// ==========================================================
	// event decode, brown-out first, then watchdog, then pin
	wire [1:0] brownout_mode = cfg_ff[CFG_BROWNOUT_MSB:CFG_BROWNOUT_LSB];
	wire evt_brownout = BROWNOUT_EVT && (brownout_mode != BROWNOUT_MODE_OFF);
	wire evt_wdog = !evt_brownout && WATCHDOG_EVT;
	wire evt_pin = !evt_brownout && !WATCHDOG_EVT && RESET_PIN_EVT;
	wire evt_irq = !evt_brownout && !WATCHDOG_EVT && !RESET_PIN_EVT &&
		IRQ_WAKE_EVT && SLEEP_ACTIVE;
	wire wdog_reset = evt_wdog && !SLEEP_ACTIVE;
	wire wdog_wake = evt_wdog && SLEEP_ACTIVE;
	wire pin_sleep = evt_pin && SLEEP_ACTIVE;
	wire pin_run = evt_pin && !SLEEP_ACTIVE;
	wire any_reset = evt_brownout || wdog_reset || evt_pin;
	wire any_wake = wdog_wake || evt_irq;
	wire evt_any = any_reset || any_wake;
	wire irq_enabled = irq_ctl_ff[GLOBAL_IRQ_EN_BIT];

	// ==========================================================
	// start-up delay selection
	wire [2:0] osc_mode = cfg_ff[CFG_OSC_MSB:CFG_OSC_LSB];
	wire is_crystal = (osc_mode < 3'(OSC_EXTERNAL_CLOCK));
	wire power_up = por_pend_ff || evt_brownout;
	// delay runs when the bit is clear
	wire pwrt_on = power_up && !cfg_ff[CFG_PWRT_N_BIT];
	// crystal count on power-up and wake
	wire ost_on = is_crystal && (power_up || any_wake);
	// no start for others without delay
	wire tmr_start = (power_up || any_wake) && (pwrt_on || ost_on);

	// hold while the delay timer runs
	startup_timer #(
		.PWRT_COUNT(PWRT_COUNT),
		.OST_COUNT(OST_COUNT)
	) startup_timer_i (
		.clk(CLK),
		.rst_n(RST_N),
		.start(tmr_start),
		.pwrt_en(pwrt_on),
		.ost_en(ost_on),
		.lf_tick(LF_TICK),
		.busy(tmr_busy)
	);

	// ==========================================================
	// program counter loading; a new event always overrides a
	// pending load so the latest cause decides the address
	wire quiet = !evt_any && !por_pend_ff && !tmr_busy;
	wire fire_load = load_pend_ff && quiet;
	// vector only after next instruction ran
	wire fire_vector = vec_pend_ff && !load_pend_ff && INSTR_DONE && quiet;
	// resets take 000h, wakes take next pc
	wire [PC_W-1:0] nxt_load_addr = any_reset ? RESET_VECTOR :
		any_wake ? NEXT_PC : load_addr_ff;
	wire [PC_W-1:0] nxt_pc_addr = fire_load ? load_addr_ff :
		fire_vector ? IRQ_VECTOR : PC_ADDR;
	wire nxt_load_pend = evt_any || (load_pend_ff && !fire_load);
	wire nxt_vec_pend = !any_reset &&
		((evt_irq && irq_enabled) || (vec_pend_ff && !fire_vector));

	// ==========================================================
	// bus write strobes and read mux
	wire we_status = wr_ff && reg_hit(addr_ff, ADDR_CPU_STATUS);
	wire we_cause = wr_ff && reg_hit(addr_ff, ADDR_RESET_CAUSE);
	wire we_irq = wr_ff && reg_hit(addr_ff, ADDR_IRQ_CONTROL);
	wire we_periph = wr_ff && reg_hit(addr_ff, ADDR_PERIPH_IRQ);
	wire we_cfg = wr_ff && reg_hit(addr_ff, ADDR_START_CONFIG);
	wire [7:0] wdata = HWDATA[DATA_MSB:0];
	// both cause flags read back in bits 1:0
	wire [31:0] rd_data =
		reg_hit(addr_ff, ADDR_CPU_STATUS) ? 32'(status_ff) :
		reg_hit(addr_ff, ADDR_RESET_CAUSE) ? 32'(cause_ff) :
		reg_hit(addr_ff, ADDR_IRQ_CONTROL) ? 32'(irq_ctl_ff) :
		reg_hit(addr_ff, ADDR_PERIPH_IRQ) ? 32'(periph_ff) :
		reg_hit(addr_ff, ADDR_START_CONFIG) ? 32'(cfg_ff) : 32'h0;
	wire xfer = HSEL && HTRANS[HTRANS_ACTIVE_BIT] && HREADY;

	// ==========================================================
	// cpu_status; timeout and powerdown are read-only to software
	wire [7:0] st_sw = we_status ? {wdata[DATA_MSB:BANK_LSB],
		status_ff[TIMEOUT_FLAG_BIT:POWERDOWN_FLAG_BIT],
		wdata[POWERDOWN_FLAG_BIT-1:0]} : status_ff;
	wire [2:0] st_bank = st_sw[DATA_MSB:BANK_LSB];
	wire [2:0] st_low = st_sw[POWERDOWN_FLAG_BIT-1:0];
	wire [3:0] st_keep4 = st_sw[TIMEOUT_FLAG_BIT-1:0];
	wire [4:0] st_keep5 = st_sw[TIMEOUT_FLAG_BIT:0];
	// pin reset flags by sleep state
	assign nxt_status =
		evt_brownout ? {BANK_ZERO, FLAGS_POWER_UP, st_low} :
		wdog_reset ? {BANK_ZERO, 1'b0, st_keep4} :
		pin_run ? {BANK_ZERO, st_keep5} :
		pin_sleep ? {BANK_ZERO, FLAGS_PIN_SLEEP, st_low} :
		wdog_wake ? {st_bank, FLAGS_WDOG_WAKE, st_low} :
		evt_irq ? {st_bank, FLAGS_IRQ_WAKE, st_low} : st_sw;

	// fixed value on brown-out, else bus write or kept
	// pin and watchdog resets keep flags
	assign nxt_cause = evt_brownout ? CAUSE_BROWNOUT :
		we_cause ? wdata[CAUSE_W-1:0] : cause_ff;

	// wake only sets its causing bits
	assign nxt_irq_ctl = any_reset ? IRQ_REG_RESET :
		(((we_irq ? wdata : irq_ctl_ff) &
		~(fire_vector ? GLOBAL_IRQ_EN_MASK : IRQ_REG_RESET)) |
		(evt_irq ? WAKE_IRQ_BITS : IRQ_REG_RESET));
	assign nxt_periph = any_reset ? IRQ_REG_RESET :
		((we_periph ? wdata : periph_ff) |
		(evt_irq ? WAKE_PERIPH_BITS : IRQ_REG_RESET));
	assign nxt_cfg = we_cfg ? wdata[CFG_W-1:0] : cfg_ff;

	// ==========================================================
	// register file; power-on values land while RST_N is low
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			cause_ff <= CAUSE_POR;
			status_ff <= STATUS_POR;
			irq_ctl_ff <= IRQ_REG_RESET;
			periph_ff <= IRQ_REG_RESET;
			cfg_ff <= CFG_RESET;
		end else begin
			cause_ff <= nxt_cause;
			status_ff <= nxt_status;
			irq_ctl_ff <= nxt_irq_ctl;
			periph_ff <= nxt_periph;
			cfg_ff <= nxt_cfg;
		end
	end

	// sequencing and pc outputs; the power-on load waits for
	// the start-up delay that por_pend_ff launches
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			por_pend_ff <= 1'b1;
			load_pend_ff <= 1'b1;
			vec_pend_ff <= 1'b0;
			load_addr_ff <= RESET_VECTOR;
			PC_LOAD <= 1'b0;
			PC_ADDR <= RESET_VECTOR;
			CHIP_HOLD <= 1'b1;
			GLOBAL_IRQ_EN <= 1'b0;
		end else begin
			por_pend_ff <= 1'b0;
			load_pend_ff <= nxt_load_pend;
			vec_pend_ff <= nxt_vec_pend;
			load_addr_ff <= nxt_load_addr;
			PC_LOAD <= fire_load || fire_vector;
			PC_ADDR <= nxt_pc_addr;
			CHIP_HOLD <= tmr_start || tmr_busy;
			GLOBAL_IRQ_EN <= nxt_irq_ctl[GLOBAL_IRQ_EN_BIT];
		end
	end

	// ahb-lite slave: writes have no wait state, reads take one
	// so a read right after a write sees the new value
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			addr_ff <= '0;
			wr_ff <= 1'b0;
			rd_ff <= 1'b0;
			HREADYOUT <= 1'b1;
			HRDATA <= 32'h0;
			HRESP <= 1'b0;
		end else begin
			addr_ff <= xfer ? HADDR[ADDR_W-1:0] : addr_ff;
			wr_ff <= xfer && HWRITE;
			rd_ff <= xfer && !HWRITE;
			HREADYOUT <= !(xfer && !HWRITE);
			HRDATA <= rd_ff ? rd_data : HRDATA;
			HRESP <= 1'b0;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	a_por_flags: assert property (
		$rose(RST_N) |-> status_ff[TIMEOUT_FLAG_BIT] &&
		status_ff[POWERDOWN_FLAG_BIT] && !cause_ff[POWER_ON_FLAG_BIT])
		else $error("power-on flags wrong after reset");
	a_bod_cause: assert property (
		evt_brownout |=> cause_ff == CAUSE_BROWNOUT &&
		status_ff[TIMEOUT_FLAG_BIT:POWERDOWN_FLAG_BIT] == FLAGS_POWER_UP)
		else $error("brown-out flags wrong");
	a_wdog_run: assert property (
		wdog_reset |=> !status_ff[TIMEOUT_FLAG_BIT] &&
		status_ff[POWERDOWN_FLAG_BIT] ==
		$past(status_ff[POWERDOWN_FLAG_BIT]))
		else $error("watchdog reset flags wrong");
	a_wdog_wake: assert property (
		wdog_wake |=> status_ff[TIMEOUT_FLAG_BIT:POWERDOWN_FLAG_BIT] ==
		FLAGS_WDOG_WAKE && cause_ff == $past(cause_ff))
		else $error("watchdog wake flags wrong");
	a_pin_sleep: assert property (
		pin_sleep |=> status_ff[TIMEOUT_FLAG_BIT:POWERDOWN_FLAG_BIT] ==
		FLAGS_PIN_SLEEP && status_ff[DATA_MSB:BANK_LSB] == BANK_ZERO)
		else $error("pin reset in sleep flags wrong");
	a_pin_run_keep: assert property (
		pin_run && !we_status && !we_cause |=>
		cause_ff == $past(cause_ff) && status_ff[TIMEOUT_FLAG_BIT:0] ==
		$past(status_ff[TIMEOUT_FLAG_BIT:0]))
		else $error("pin reset while running changed kept bits");
	a_irq_clear: assert property (
		any_reset |=> irq_ctl_ff == IRQ_REG_RESET &&
		periph_ff == IRQ_REG_RESET ##1 !GLOBAL_IRQ_EN)
		else $error("interrupt registers not cleared");
	a_pin_vector: assert property (
		evt_pin && !tmr_busy ##1 !evt_any && !tmr_busy
		|=> PC_LOAD && PC_ADDR == RESET_VECTOR)
		else $error("pin reset did not load 000h");
	a_irq_vector: assert property (
		fire_vector |=> PC_LOAD && PC_ADDR == IRQ_VECTOR && !GLOBAL_IRQ_EN)
		else $error("interrupt vector not loaded");
	a_hold_delay: assert property (
		tmr_start |=> CHIP_HOLD ##1 CHIP_HOLD)
		else $error("start-up delay did not hold the chip");

	c_brownout: cover property (evt_brownout ##[1:1000] PC_LOAD);
	c_wdog_wake: cover property (wdog_wake ##[1:1000] PC_LOAD);
	c_irq_vector: cover property (evt_irq && irq_enabled ##[1:1000] fire_vector);
	c_wdog_reset: cover property (wdog_reset ##[1:1000] PC_LOAD);
	c_pin_sleep: cover property (pin_sleep ##[1:1000] PC_LOAD);

endmodule

// File: tb/reset_cause_init_bench.sv
// self-checking bench for the reset cause and init block
// assumes reset_cause_pkg is compiled first; one 10 MHz clock
module reset_cause_init_bench
	import reset_cause_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================================
	// signals and model state
	// short timer counts keep each start-up hold to a few dozen cycles
	localparam int PW = 4;
	localparam int OW = 8;
	logic clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic bo_evt, wd_evt, pin_evt, irq_evt, sleep, instr_done, lf_tick;
	logic [7:0] wake_irq, wake_per;
	logic [12:0] next_pc, pc_addr;
	logic chip_hold, pc_load, irq_en_out;
	logic [1:0] lf_cnt_ff;
	int fail_count, checked;
	int st, cs, ic, pf, cfg, np, wi, wp;
	int tbl[17] = '{'h190, 'h3c0, 'h1c0, 'h3a0, 'h040, 'h192, 'h193,
		'h1b3, 'h194, 'h195, 'h1c7, 'h187, 'h1d7, 'h1c6, 'h1c3, 'h0a0,
		'h1e7};

	// single slave: its ready is the bus ready
	assign hready = hreadyout;

	reset_cause_init #(.PWRT_COUNT(PW), .OST_COUNT(OW)) reset_cause_init_i (
		.CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
		.HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hreadyout),
		.HRESP(hresp), .BROWNOUT_EVT(bo_evt), .WATCHDOG_EVT(wd_evt),
		.RESET_PIN_EVT(pin_evt), .IRQ_WAKE_EVT(irq_evt),
		.WAKE_IRQ_BITS(wake_irq), .WAKE_PERIPH_BITS(wake_per),
		.SLEEP_ACTIVE(sleep), .INSTR_DONE(instr_done), .NEXT_PC(next_pc),
		.LF_TICK(lf_tick), .CHIP_HOLD(chip_hold), .PC_LOAD(pc_load),
		.PC_ADDR(pc_addr), .GLOBAL_IRQ_EN(irq_en_out));

	// ==========================================================
	// clock and low-frequency tick, one tick every fourth cycle
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			lf_cnt_ff <= 2'h0;
			lf_tick <= 1'b0;
		end else begin
			lf_cnt_ff <= lf_cnt_ff + 2'h1;
			lf_tick <= (lf_cnt_ff == 2'h3);
		end
	end

	// ==========================================================
	// compare, bus and event tasks
	task automatic chk(input string nm, input int exp, input logic [31:0] got);
		checked++;
		if (got !== 32'(exp)) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// address phase held until ready, then data phase held until ready
	task automatic bus(input logic [11:0] a, input logic w, input int d,
		output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {20'h0, a};
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= 32'(d);
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	task automatic wr(input logic [11:0] a, input int d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask

	task automatic rd(input logic [11:0] a, input int e, input string nm);
		logic [31:0] q;
		bus(a, 1'b0, 0, q);
		chk(nm, e, q);
	endtask

	task automatic rd_all;
		rd(ADDR_CPU_STATUS, st, "cpu_status");
		rd(ADDR_RESET_CAUSE, cs, "reset_cause");
		rd(ADDR_IRQ_CONTROL, ic, "irq_control");
		rd(ADDR_PERIPH_IRQ, pf, "periph_irq");
	endtask

	// waits for the next pc load; eh 2 means the hold is not judged
	task automatic wait_load(input int pc, input int eh);
		int n;
		logic seen;
		n = 0;
		seen = 1'b0;
		do begin
			@(posedge clk);
			instr_done <= 1'b0;
			#1;
			seen |= chip_hold;
			n++;
		end while (pc_load !== 1'b1 && n < 3000);
		chk("pc_load", 1, pc_load);
		chk("pc_addr", pc, pc_addr);
		if (eh != 2) chk("chip_hold", eh, seen);
	endtask

	task automatic fire(input int k, input logic slp);
		@(posedge clk);
		sleep <= slp;
		next_pc <= 13'($urandom);
		wake_irq <= 8'($urandom) & 8'h7f;
		wake_per <= 8'($urandom);
		case (k)
			0: bo_evt <= 1'b1;
			1: wd_evt <= 1'b1;
			2: pin_evt <= 1'b1;
			default: irq_evt <= 1'b1;
		endcase
		@(posedge clk);
		{bo_evt, wd_evt, pin_evt, irq_evt} <= 4'h0;
		sleep <= 1'b0;
		np = next_pc;
		wi = wake_irq;
		wp = wake_per;
	endtask

	// power-on reset, then the start-up hold with the default config
	task automatic por;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		st = 'h18;
		cs = 4;
		ic = 0;
		pf = 0;
		cfg = 'h19;
		wait_load(0, 1);
		rd_all;
	endtask

	task automatic wrap_up;
		$display("checks %0d errors %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ==========================================================
	// hang guard, far beyond the thousand or so cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		wrap_up;
	end

	// ==========================================================
	// main sequence: table of config, event kind and sleep state
	initial begin
		int e, k, s, n, d, xtal, g;
		{rst_n, hsel, hwrite, bo_evt, wd_evt, pin_evt, irq_evt} = 7'h0;
		{sleep, instr_done} = 2'h0;
		{haddr, hwdata, htrans, hsize} = 69'h0;
		{wake_irq, wake_per, next_pc} = 29'h0;
		fail_count = 0;
		checked = 0;
		void'($urandom(32'h0bbe151c));
		por;
		wr(12'h200, $urandom);
		rd(12'h200, 0, "unmapped");
		chk("hresp", 0, hresp);
		foreach (tbl[i]) begin
			e = tbl[i];
			cfg = e >> 4;
			k = (e >> 1) & 7;
			s = e & 1;
			xtal = ((cfg & 7) < 3);
			wr(ADDR_START_CONFIG, cfg);
			cs = $urandom & 7;
			wr(ADDR_RESET_CAUSE, cs);
			d = $urandom & 'hff;
			st = (d & 'he7) | (st & 'h18);
			wr(ADDR_CPU_STATUS, d);
			ic = $urandom & 'hff;
			wr(ADDR_IRQ_CONTROL, ic);
			pf = $urandom & 'hff;
			wr(ADDR_PERIPH_IRQ, pf);
			fire(k, s[0]);
			if ((k == 0 && (cfg & 'h18) == 0) || (k == 3 && s == 0)) begin
				n = 0;
				repeat (30) begin
					@(posedge clk);
					#1;
					if (pc_load !== 1'b0) n++;
				end
				chk("ignored_load", 0, n);
			end else begin
				case (k)
					0: begin
						st = (st & 7) | 'h18;
						cs = 6;
						ic = 0;
						pf = 0;
						wait_load(0, xtal | ((cfg >> 5) ^ 1));
					end
					1: if (s) begin
						st = st & 'he7;
						wait_load(np, xtal);
					end else begin
						st = st & 'h0f;
						ic = 0;
						pf = 0;
						wait_load(0, 0);
					end
					2: begin
						st = s ? (st & 7) | 'h10 : st & 'h1f;
						ic = 0;
						pf = 0;
						wait_load(0, 0);
					end
					default: begin
						st = (st & 'he7) | 'h10;
						g = (ic >> 7) & 1;
						ic |= wi;
						pf |= wp;
						wait_load(np, xtal);
						if (g) begin
							@(posedge clk);
							instr_done <= 1'b1;
							ic &= 'h7f;
							wait_load(4, 0);
						end
					end
				endcase
			end
			rd_all;
			chk("global_irq_en", (ic >> 7) & 1, irq_en_out);
		end
		// a second power-on after the table clears power_on_flag again
		por;
		wrap_up;
	end
endmodule
